// ---- hw/printer_motor_control.sv ----
//Function
// - latch host data byte on strobe
// - busy held while byte is processed
// - done: drop busy, pulse acknowledge
// - initialize at power-on and host init
// - board reset output resets block, except synchronisers, reset generator and encoder phase history
// - interface outputs only after firmware ready
// - latch low eight address bits
// - decode five high bits to bank select
// - ramp carriage speed, regulate to mode
// - dot timing pulse from encoder phases
// - divide encoder edges by pitch ratio
// - three coil phases plus overdrive per command
// - fixed-period overdrive, firmware width limits drive
// - torque boost only while ramping
// - general ports follow microprocessor commands
`timescale 1ns/1ps
`default_nettype none
module printer_motor_control (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic [7:0]  hostData,
	input  wire logic        hostStrobe_n,
	input  wire logic        host_init_request,
	output var  logic        hostBusy,
	output var  logic        hostAck_n,
	output var  logic        selectLed,
	output var  logic        board_reset_output,
	input  wire logic        addrLatchEnable,
	input  wire logic [7:0]  adBus,
	input  wire logic [4:0]  addrHigh,
	output var  logic [7:0]  latchedAddr,
	output var  logic        ram_bank_select_n,
	input  wire logic        encPhaseA,
	input  wire logic        encPhaseB,
	output var  logic        dot_timing_pulse_n,
	output var  logic        carriage_coil_u,
	output var  logic        carriage_coil_v,
	output var  logic        carriage_coil_w,
	output var  logic        carriage_overdrive_pulse,
	output var  logic        carriage_torque_boost,
	input  wire logic [7:0]  gpioIn,
	output var  logic [7:0]  gpioOut
);
	import motor_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisation
	logic [33:0] pinsS;          // all pins after two flops
	logic        encAS, encBS;   // encoder phases
	logic        strobeS_n;      // host strobe
	logic        initS;          // host init request
	logic        aleS;           // address latch enable
	logic [7:0]  adS;            // multiplexed low address
	logic [4:0]  addrHighS;      // high address bits
	logic [7:0]  hostDataS;      // host data byte
	logic [7:0]  gpioInS;        // general inputs

	pin_sync #(.WIDTH(34)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pinIn   ({encPhaseA, encPhaseB, hostStrobe_n, host_init_request, addrLatchEnable,
		           adBus, addrHigh, hostData, gpioIn}),
		.syncOut (pinsS)
	);
	assign {encAS, encBS, strobeS_n, initS, aleS, adS, addrHighS, hostDataS, gpioInS} = pinsS;

	////////////////////////////////////////////////////////////////////////
	// board reset generator
	logic [10:0] rstCnt_r;   // hold counter
	logic        initPrev_r; // previous init level
	logic        intRst;     // reset of all but synchronisers, reset generator and encoder phase history

	// power-on and host init both restart the hold
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rstCnt_r   <= 11'(RST_HOLD_CYC);
			initPrev_r <= 1'b0;
		end else begin
			initPrev_r <= initS;
			if (initS && !initPrev_r)
				rstCnt_r <= 11'(RST_HOLD_CYC);
			else if (rstCnt_r != 11'h000)
				rstCnt_r <= rstCnt_r - 11'h001;
		end
	end

	// output drives the processor, and this block too
	always_ff @(posedge clk) begin
		if (sys_rst)
			board_reset_output <= 1'b1;
		else
			board_reset_output <= (rstCnt_r != 11'h000);
	end
	assign intRst = sys_rst | board_reset_output;

	////////////////////////////////////////////////////////////////////////
	// register file
	logic [1:0]  ctrl_r;     // ready, select
	logic [15:0] speed_r;    // target step period
	logic [7:0]  ovdWidth_r; // overdrive pulse width
	logic [7:0]  encDiv_r;   // encoder divide ratio
	logic        wrEn;       // write taken this edge
	logic        setup;      // apb setup cycle
	logic        ackWrite;   // firmware done with byte
	logic        cmdWrite;   // new spacing command
	logic [31:0] rdData;     // read mux
	logic        rdHit;      // address is mapped
	logic [7:0]  hostByte_r; // latched host byte
	logic        byteValid_r;
	logic        moving;
	logic [15:0] remain_r;
	logic [15:0] position_r;
	motion_t     state_r;

	assign setup    = psel && !penable;
	assign wrEn     = psel && penable && pready && pwrite;
	assign ackWrite = wrEn && (paddr == ADDR_HOST_ACK) && pwdata[0];
	assign cmdWrite = wrEn && (paddr == ADDR_SPACE_CMD);
	assign moving   = (state_r != MV_IDLE);

	// read decode, unmapped gives zero and an error
	always_comb begin
		rdData = 32'h0000_0000;
		rdHit  = 1'b1;
		case (paddr)
			ADDR_CTRL:      rdData = {30'h0, ctrl_r};
			ADDR_HOST_DATA: rdData = {23'h0, byteValid_r, hostByte_r};
			ADDR_HOST_ACK:  rdData = 32'h0000_0000;
			ADDR_SPACE_CMD: rdData = {15'h0, moving, remain_r};
			ADDR_SPEED:     rdData = {16'h0, speed_r};
			ADDR_OVD_WIDTH: rdData = {24'h0, ovdWidth_r};
			ADDR_ENC_DIV:   rdData = {24'h0, encDiv_r};
			ADDR_GPIO_OUT:  rdData = {24'h0, gpioOut};
			ADDR_GPIO_IN:   rdData = {24'h0, gpioInS};
			ADDR_STATUS:    rdData = {28'h0, byteValid_r, carriage_torque_boost, moving, hostBusy};
			ADDR_POSITION:  rdData = {16'h0, position_r};
			ADDR_LATCH:     rdData = {24'h0, latchedAddr};
			default:        rdHit  = 1'b0;
		endcase
	end

	// one wait-free access: answer prepared in the setup cycle
	always_ff @(posedge clk) begin
		if (intRst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0000_0000 : rdData;
			pslverr <= !rdHit;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// writable registers, cleared by either reset
	always_ff @(posedge clk) begin
		if (intRst) begin
			ctrl_r     <= CTRL_RESET;
			speed_r    <= SPEED_RESET;
			ovdWidth_r <= OVD_WIDTH_RESET;
			encDiv_r   <= ENC_DIV_RESET;
			gpioOut    <= GPIO_OUT_RESET;
		end else if (wrEn) begin
			case (paddr)
				ADDR_CTRL:      ctrl_r     <= pwdata[1:0];
				ADDR_SPEED:     speed_r    <= pwdata[15:0];
				ADDR_OVD_WIDTH: ovdWidth_r <= pwdata[7:0];
				ADDR_ENC_DIV:   encDiv_r   <= pwdata[7:0];
				ADDR_GPIO_OUT:  gpioOut    <= pwdata[7:0];
				default:        ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host parallel handshake
	logic       strobePrev_n_r; // previous strobe level
	logic       strobeFall;     // strobe leading edge
	logic [5:0] ackCnt_r;       // acknowledge width

	assign strobeFall = strobePrev_n_r && !strobeS_n;

	// byte latch; a strobe while busy is ignored
	always_ff @(posedge clk) begin
		if (intRst) begin
			strobePrev_n_r <= 1'b1;
			hostByte_r     <= 8'h00;
			byteValid_r    <= 1'b0;
		end else begin
			strobePrev_n_r <= strobeS_n;
			if (strobeFall && !hostBusy) begin
				hostByte_r  <= hostDataS;
				byteValid_r <= 1'b1;
			end else if (ackWrite)
				byteValid_r <= 1'b0;
		end
	end

	// busy until firmware ready, then per byte
	always_ff @(posedge clk) begin
		if (intRst)
			hostBusy <= 1'b1;
		else if (!ctrl_r[CTRL_READY_BIT])
			hostBusy <= 1'b1;
		else if (strobeFall && !hostBusy)
			hostBusy <= 1'b1;
		else if (ackWrite)
			hostBusy <= 1'b0;
		else if (!byteValid_r && ackCnt_r == 6'h00)
			hostBusy <= 1'b0;
	end

	// acknowledge pulse when processing ends
	always_ff @(posedge clk) begin
		if (intRst) begin
			ackCnt_r  <= 6'h00;
			hostAck_n <= 1'b1;
		end else begin
			if (ackWrite && ctrl_r[CTRL_READY_BIT])
				ackCnt_r <= 6'(ACK_CYC);
			else if (ackCnt_r != 6'h00)
				ackCnt_r <= ackCnt_r - 6'h01;
			hostAck_n <= !((ackWrite && ctrl_r[CTRL_READY_BIT]) || ackCnt_r > 6'h01);
		end
	end

	// select lamp only after firmware says so
	always_ff @(posedge clk) begin
		if (intRst)
			selectLed <= 1'b0;
		else
			selectLed <= ctrl_r[CTRL_SELECT_BIT] && ctrl_r[CTRL_READY_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// address latch and decoder

	// transparent while the latch enable is high, holds once it falls;
	// synced bus and enable move together, so an edge capture would
	// take the data that follows the address
	always_ff @(posedge clk) begin
		if (intRst)
			latchedAddr <= 8'h00;
		else if (aleS)
			latchedAddr <= adS;
	end

	// bank select low on a high-address match
	always_ff @(posedge clk) begin
		if (intRst)
			ram_bank_select_n <= 1'b1;
		else
			ram_bank_select_n <= (addrHighS != BANK_MATCH);
	end

	////////////////////////////////////////////////////////////////////////
	// encoder edge divider and dot timing
	logic       encAPrev_r, encBPrev_r;
	logic       encEdge;     // any phase edge
	logic [7:0] edgeCnt_r;   // edges since last dot
	logic [7:0] divEff;      // zero ratio acts as one

	assign encEdge = (encAS != encAPrev_r) || (encBS != encBPrev_r);
	assign divEff  = (encDiv_r == 8'h00) ? 8'h01 : encDiv_r;

	// phase history keeps tracking through board reset, so a carriage
	// parked with a phase high gives no false edge when reset ends
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			encAPrev_r <= 1'b0;
			encBPrev_r <= 1'b0;
		end else begin
			encAPrev_r <= encAS;
			encBPrev_r <= encBS;
		end
	end

	// one-cycle low dot pulse every divEff edges
	always_ff @(posedge clk) begin
		if (intRst) begin
			edgeCnt_r          <= 8'h00;
			dot_timing_pulse_n <= 1'b1;
			position_r         <= 16'h0000;
		end else begin
			dot_timing_pulse_n <= 1'b1;
			if (encEdge) begin
				position_r <= position_r + 16'h0001;
				if (edgeCnt_r + 8'h01 >= divEff) begin
					edgeCnt_r          <= 8'h00;
					dot_timing_pulse_n <= 1'b0;
				end else
					edgeCnt_r <= edgeCnt_r + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// carriage motion: ramp, cruise, ramp down
	logic [15:0] period_r;   // current step period
	logic [15:0] stepTmr_r;  // cycles to next step
	logic [15:0] rampSteps_r;// steps spent accelerating
	logic [1:0]  phase_r;    // commutation phase
	logic        dir_r;      // direction
	logic        stepNow;    // a step happens now
	logic [15:0] target;     // regulated period

	assign target  = (speed_r > 16'(START_PERIOD_CYC)) ? 16'(START_PERIOD_CYC) : speed_r;
	assign stepNow = moving && (stepTmr_r == 16'h0000);

	// speed profile from commands
	always_ff @(posedge clk) begin
		if (intRst) begin
			state_r     <= MV_IDLE;
			period_r    <= 16'(START_PERIOD_CYC);
			stepTmr_r   <= 16'h0000;
			remain_r    <= 16'h0000;
			rampSteps_r <= 16'h0000;
			dir_r       <= 1'b0;
		end else if (cmdWrite && !moving && pwdata[15:0] != 16'h0000) begin
			state_r     <= MV_ACCEL;
			period_r    <= 16'(START_PERIOD_CYC);
			stepTmr_r   <= 16'(START_PERIOD_CYC);
			remain_r    <= pwdata[15:0];
			rampSteps_r <= 16'h0000;
			dir_r       <= pwdata[CMD_DIR_BIT];
		end else if (moving) begin
			if (!stepNow)
				stepTmr_r <= stepTmr_r - 16'h0001;
			else begin
				remain_r  <= remain_r - 16'h0001;
				stepTmr_r <= period_r;
				case (state_r)
					MV_ACCEL: begin
						rampSteps_r <= rampSteps_r + 16'h0001;
						if (remain_r - 16'h0001 <= rampSteps_r + 16'h0001)
							state_r <= MV_DECEL;
						else if (period_r <= target + RAMP_DELTA) begin
							period_r <= target;
							state_r  <= MV_CRUISE;
						end else
							period_r <= period_r - RAMP_DELTA;
					end
					MV_CRUISE: begin
						if (remain_r - 16'h0001 <= rampSteps_r)
							state_r <= MV_DECEL;
					end
					MV_DECEL: begin
						if (period_r < 16'(START_PERIOD_CYC) - RAMP_DELTA)
							period_r <= period_r + RAMP_DELTA;
					end
					default: state_r <= MV_IDLE;
				endcase
				if (remain_r == 16'h0001)
					state_r <= MV_IDLE;
			end
		end
	end

	// commutation advances once per step
	always_ff @(posedge clk) begin
		if (intRst)
			phase_r <= 2'h0;
		else if (stepNow) begin
			if (dir_r)
				phase_r <= (phase_r == 2'h0) ? 2'h2 : phase_r - 2'h1;
			else
				phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// overdrive and coil outputs
	logic [7:0] ovdCnt_r;  // position in fixed period
	logic       ovdOn;     // overdrive window now

	assign ovdOn = moving && (ovdCnt_r < ovdWidth_r);

	// fixed period, firmware width
	always_ff @(posedge clk) begin
		if (intRst || !moving)
			ovdCnt_r <= 8'h00;
		else if (ovdCnt_r == 8'(OVD_PERIOD_CYC - 1))
			ovdCnt_r <= 8'h00;
		else
			ovdCnt_r <= ovdCnt_r + 8'h01;
	end

	// coils only inside the window, so width caps drive time
	always_ff @(posedge clk) begin
		if (intRst) begin
			carriage_overdrive_pulse <= 1'b0;
			carriage_coil_u          <= 1'b0;
			carriage_coil_v          <= 1'b0;
			carriage_coil_w          <= 1'b0;
		end else begin
			carriage_overdrive_pulse <= ovdOn;
			carriage_coil_u          <= ovdOn && (phase_r == 2'h0);
			carriage_coil_v          <= ovdOn && (phase_r == 2'h1);
			carriage_coil_w          <= ovdOn && (phase_r == 2'h2);
		end
	end

	// extra torque only while ramping
	always_ff @(posedge clk) begin
		if (intRst)
			carriage_torque_boost <= 1'b0;
		else
			carriage_torque_boost <= (state_r == MV_ACCEL) || (state_r == MV_DECEL);
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (intRst);

	chk_busy_on_strobe: assert property (
		strobeFall && !hostBusy && ctrl_r[CTRL_READY_BIT] |=> hostBusy && byteValid_r && hostByte_r == $past(hostDataS)
	) else $error("strobe did not latch byte and raise busy");

	chk_ack_after_done: assert property (
		ackWrite && ctrl_r[CTRL_READY_BIT] |=> !hostAck_n && !hostBusy ##1 !hostAck_n[*4]
	) else $error("acknowledge pulse missing after done");

	chk_busy_not_ready: assert property (
		!ctrl_r[CTRL_READY_BIT] |=> hostBusy && !selectLed
	) else $error("interface released before ready");

	chk_bank_decode: assert property (
		(addrHighS == BANK_MATCH) |=> !ram_bank_select_n
	) else $error("bank select not asserted on match");

	chk_addr_latch: assert property (
		aleS |=> latchedAddr == $past(adS)
	) else $error("low address not latched");

	chk_addr_hold: assert property (
		!aleS |=> $stable(latchedAddr)
	) else $error("latched address moved while latch closed");

	chk_boost_ramp: assert property (
		carriage_torque_boost |-> $past(state_r) == MV_ACCEL || $past(state_r) == MV_DECEL
	) else $error("torque boost outside ramp");

	chk_coil_window: assert property (
		(carriage_coil_u || carriage_coil_v || carriage_coil_w) |-> carriage_overdrive_pulse
	) else $error("coil driven outside overdrive window");

	chk_dot_single: assert property (
		!dot_timing_pulse_n |=> dot_timing_pulse_n
	) else $error("dot pulse longer than one cycle");

	chk_gpio_write: assert property (
		wrEn && paddr == ADDR_GPIO_OUT |=> gpioOut == $past(pwdata[7:0])
	) else $error("general output not updated");

	chk_init_hold: assert property (
		@(posedge clk) disable iff (sys_rst) initS && !initPrev_r |-> ##2 board_reset_output[*8]
	) else $error("board reset not held after init");
endmodule // printer_motor_control
`default_nettype wire

// ---- hw/motor_ctrl_pkg.sv ----
`default_nettype none
package motor_ctrl_pkg;
	// clock
	localparam int CLK_PERIOD_NS = 100;
	// apb register byte addresses
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_HOST_DATA = 8'h04;
	localparam logic [7:0] ADDR_HOST_ACK  = 8'h08;
	localparam logic [7:0] ADDR_SPACE_CMD = 8'h0C;
	localparam logic [7:0] ADDR_SPEED     = 8'h10;
	localparam logic [7:0] ADDR_OVD_WIDTH = 8'h14;
	localparam logic [7:0] ADDR_ENC_DIV   = 8'h18;
	localparam logic [7:0] ADDR_GPIO_OUT  = 8'h1C;
	localparam logic [7:0] ADDR_GPIO_IN   = 8'h20;
	localparam logic [7:0] ADDR_STATUS    = 8'h24;
	localparam logic [7:0] ADDR_POSITION  = 8'h28;
	localparam logic [7:0] ADDR_LATCH     = 8'h2C;
	// field positions
	localparam int CTRL_READY_BIT  = 0;
	localparam int CTRL_SELECT_BIT = 1;
	localparam int CMD_DIR_BIT     = 16;
	localparam int DATA_VALID_BIT  = 8;
	// values after reset
	localparam logic [1:0]  CTRL_RESET      = 2'h0;
	localparam logic [15:0] SPEED_RESET     = 16'h0000;
	localparam logic [7:0]  OVD_WIDTH_RESET = 8'h00;
	localparam logic [7:0]  ENC_DIV_RESET   = 8'h00;
	localparam logic [7:0]  GPIO_OUT_RESET  = 8'h00;
	// high address match for the ram bank select
	localparam logic [4:0] BANK_MATCH = 5'h04;
	// times and derived cycle counts
	localparam int OVD_PERIOD_NS  = 25600;
	localparam int OVD_PERIOD_CYC = OVD_PERIOD_NS / CLK_PERIOD_NS;
	localparam int ACK_WIDTH_NS   = 5000;
	localparam int ACK_CYC        = (ACK_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_HOLD_NS    = 100000;
	localparam int RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int START_PERIOD_NS  = 400000;
	localparam int START_PERIOD_CYC = START_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [15:0] RAMP_DELTA = 16'h00C8;
	// carriage motion states
	typedef enum logic [1:0] {MV_IDLE, MV_ACCEL, MV_CRUISE, MV_DECEL} motion_t;
endpackage
`default_nettype wire

// ---- hw/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser, one chain per bit
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] pinIn,
	output var  logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_r; // first stage, read only by the second

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// each bit on its own two flops
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					meta_r[i]  <= 1'b0;
					syncOut[i] <= 1'b0;
				end else begin
					meta_r[i]  <= pinIn[i];
					syncOut[i] <= meta_r[i];
				end
			end
		end
	endgenerate
endmodule // pin_sync
`default_nettype wire

// ---- verification/host_port_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host end of the parallel port: one byte per request, init pulse on request
module host_port_model (
	input  wire logic       clk,
	input  wire logic       sendGo,
	input  wire logic [7:0] sendByte,
	input  wire logic       initGo,
	output var  logic [7:0] hostData,
	output var  logic       hostStrobe_n,
	output var  logic       host_init_request
);
	int hold; // cycles left of strobe and data hold
	initial begin
		hold = 0;
		hostData = 8'h00;
		hostStrobe_n = 1'b1;
		host_init_request = 1'b0;
	end
	// strobe low 8 cycles, data held 2 more, then released lines toggle
	always @(posedge clk) begin
		host_init_request <= initGo;
		if (sendGo) begin
			hostData <= sendByte;
			hostStrobe_n <= 1'b0;
			hold <= 10;
		end else if (hold > 0) begin
			hold <= hold - 1;
			if (hold == 3) hostStrobe_n <= 1'b1;
			if (hold == 1) hostData <= ~hostData; // no stale byte after release
		end
	end
endmodule // host_port_model
`default_nettype wire

// ---- verification/printer_motor_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module printer_motor_control_tb;
	import motor_ctrl_pkg::*;
	logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [7:0] paddr = 0, hostData, gpioIn = 0, adBus = 0, latchedAddr, gpioOut, sendByte = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [4:0] addrHigh = 0;
	logic hostStrobe_n, host_init_request, hostBusy, hostAck_n, selectLed, board_reset_output;
	logic addrLatchEnable = 0, ram_bank_select_n, encPhaseA = 0, encPhaseB = 0, dot_timing_pulse_n;
	logic carriage_coil_u, carriage_coil_v, carriage_coil_w, carriage_overdrive_pulse, carriage_torque_boost;
	logic sendGo = 0, initGo = 0;
	logic [2:0] coilSeen = 0; // which coils were ever energized
	int n_errors = 0, n_compared = 0, nDot = 0, n, m;

	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (!dot_timing_pulse_n) nDot++;
		coilSeen <= coilSeen | {carriage_coil_w, carriage_coil_v, carriage_coil_u};
	end

	printer_motor_control uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hostData(hostData), .hostStrobe_n(hostStrobe_n),
		.host_init_request(host_init_request), .hostBusy(hostBusy), .hostAck_n(hostAck_n),
		.selectLed(selectLed), .board_reset_output(board_reset_output),
		.addrLatchEnable(addrLatchEnable), .adBus(adBus), .addrHigh(addrHigh),
		.latchedAddr(latchedAddr), .ram_bank_select_n(ram_bank_select_n), .encPhaseA(encPhaseA),
		.encPhaseB(encPhaseB), .dot_timing_pulse_n(dot_timing_pulse_n),
		.carriage_coil_u(carriage_coil_u), .carriage_coil_v(carriage_coil_v),
		.carriage_coil_w(carriage_coil_w), .carriage_overdrive_pulse(carriage_overdrive_pulse),
		.carriage_torque_boost(carriage_torque_boost), .gpioIn(gpioIn), .gpioOut(gpioOut));
	host_port_model host (.clk(clk), .sendGo(sendGo), .sendByte(sendByte), .initGo(initGo),
		.hostData(hostData), .hostStrobe_n(hostStrobe_n), .host_init_request(host_init_request));

	////////////////////////////////////////////////////////////////
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// bounded wait; n returns edges seen before the level showed
	task automatic waitSig(ref logic s, input logic v, input int lim, output int k);
		k = 0;
		while (s !== v && k < lim) begin
			@(posedge clk);
			k++;
		end
		if (k >= lim) begin
			chk("wait timeout", 0, 1);
			finish_test();
		end
	endtask
	task cyc(input int c);
		repeat (c) @(posedge clk);
	endtask
	// one apb transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		waitSig(pready, 1, 20, n);
		if (n == 0) waitSig(pready, 1, 20, n);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	////////////////////////////////////////////////////////////////
	task t_reset;
		chk("reset out", 1, board_reset_output);
		chk("busy at reset", 1, hostBusy);
		chk("bank sel", 1, ram_bank_select_n);
		waitSig(board_reset_output, 0, 1100, n);
		apb(0, ADDR_OVD_WIDTH, 0);
		chk("ovd width", 0, rd);
		apb(0, ADDR_ENC_DIV, 0);
		chk("enc div", 0, rd);
		apb(0, 8'h3C, 0);
		chk("unmapped err", 1, er);
		$display("test reset done");
	endtask
	task t_host;
		sendByte <= 8'h66;
		sendGo <= 1;
		cyc(1);
		sendGo <= 0;
		cyc(20);
		chk("busy before ready", 1, hostBusy);
		apb(1, ADDR_CTRL, 32'h3);
		cyc(2);
		chk("select led", 1, selectLed);
		chk("busy idle", 0, hostBusy);
		sendByte <= 8'hA5;
		sendGo <= 1;
		cyc(1);
		sendGo <= 0;
		waitSig(hostBusy, 1, 6, n);
		apb(0, ADDR_HOST_DATA, 0);
		chk("host byte", 32'h1A5, rd);
		sendByte <= 8'h3C;
		sendGo <= 1;
		cyc(1);
		sendGo <= 0;
		cyc(20);
		apb(0, ADDR_HOST_DATA, 0);
		chk("byte kept while busy", 32'h1A5, rd);
		chk("still busy", 1, hostBusy);
		apb(1, ADDR_HOST_ACK, 1);
		waitSig(hostAck_n, 0, 3, n);
		chk("busy off", 0, hostBusy);
		waitSig(hostAck_n, 1, 100, n);
		chk("ack width", ACK_CYC, n);
		$display("test host done");
	endtask
	task t_addr;
		adBus <= 8'h5A;
		addrLatchEnable <= 1;
		addrHigh <= 5'h04;
		cyc(3);
		addrLatchEnable <= 0;
		adBus <= 8'hA5; // bus moves on to data after the latch edge
		cyc(8);
		chk("latched addr", 8'h5A, latchedAddr);
		chk("bank sel on", 0, ram_bank_select_n);
		apb(0, ADDR_LATCH, 0);
		chk("latch reg", 8'h5A, rd);
		addrHigh <= 5'h05;
		cyc(6);
		chk("bank sel off", 1, ram_bank_select_n);
		$display("test addr done");
	endtask
	task t_gpio;
		apb(1, ADDR_GPIO_OUT, 32'hC3);
		gpioIn <= 8'h3C;
		cyc(4);
		chk("gpio out", 8'hC3, gpioOut);
		apb(0, ADDR_GPIO_IN, 0);
		chk("gpio in", 8'h3C, rd);
		$display("test gpio done");
	endtask
	task t_enc;
		apb(1, ADDR_ENC_DIV, 3);
		nDot = 0;
		repeat (3) begin
			encPhaseA <= ~encPhaseA;
			cyc(4);
			encPhaseB <= ~encPhaseB;
			cyc(4);
		end
		cyc(8);
		chk("dot pulses", 2, nDot);
		apb(0, ADDR_POSITION, 0);
		chk("position", 6, rd);
		$display("test encoder done");
	endtask
	task t_move;
		apb(1, ADDR_OVD_WIDTH, 32'h40);
		apb(1, ADDR_SPEED, 3600);
		apb(1, ADDR_SPACE_CMD, 6);
		waitSig(carriage_torque_boost, 1, 5, n);
		apb(0, ADDR_STATUS, 0);
		chk("moving", 1, rd[1]);
		waitSig(carriage_overdrive_pulse, 0, 300, n);
		waitSig(carriage_overdrive_pulse, 1, 300, n);
		waitSig(carriage_overdrive_pulse, 0, 300, n);
		chk("ovd width", 64, n);
		waitSig(carriage_overdrive_pulse, 1, 300, m);
		chk("ovd period", OVD_PERIOD_CYC, n + m);
		rd = 2;
		for (int i = 0; i < 500 && rd[1] !== 1'b0; i++) begin
			cyc(100);
			apb(0, ADDR_STATUS, 0);
		end
		apb(0, ADDR_STATUS, 0);
		chk("move ended", 0, rd[2:1]);
		chk("coils used", 3'h7, coilSeen);
		$display("test move done");
	endtask
	task t_init;
		initGo <= 1;
		cyc(1);
		initGo <= 0;
		waitSig(board_reset_output, 1, 8, n);
		waitSig(board_reset_output, 0, 1100, n);
		chk("gpio cleared", 0, gpioOut);
		apb(0, ADDR_CTRL, 0);
		chk("ctrl cleared", 0, rd);
		$display("test init done");
	endtask

	initial begin
		cyc(3);
		sys_rst <= 0;
		cyc(1);
		t_reset();
		t_host();
		t_addr();
		t_gpio();
		t_enc();
		t_move();
		t_init();
		finish_test();
	end
endmodule // printer_motor_control_tb
`default_nettype wire
